// >>> dv/sbr_checker.sv
// Port-level assertions for the serial boot command responder
`default_nettype none

module sbr_checker
   import sbr_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst_b,
   input wire sbr_rx_s     rx,
   input wire logic        rxReady,
   input wire logic        modeSync,
   input wire logic        baudOk,
   input wire logic        smallVariant,
   input wire logic  [6:0] headIndex,
   input wire logic  [7:0] headByte,
   input wire logic        txValid,
   input wire logic  [7:0] txData,
   input wire logic        txReady,
   input wire logic        eraseStart,
   input wire logic        eraseDone,
   input wire logic        eraseErr,
   input wire logic        extStart,
   input wire logic  [7:0] extCmd,
   input wire sbr_extack_s extAck,
   input wire logic        extDone,
   input wire logic        syncMode,
   input wire logic        dead
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // Erase launch
   sequence s_keyOut;
      txValid && txData == ERASE_KEY;
   endsequence
   sequence s_noRestart;
      !eraseStart [*8];
   endsequence
   property p_startEcho;
      eraseStart |-> s_keyOut ##1 !eraseStart;
   endproperty
   a_startEcho: assert property (p_startEcho)
      else $error("erase start without key echo");
   property p_eraseGap;
      eraseStart |=> s_noRestart;
   endproperty
   a_eraseGap: assert property (p_eraseGap)
      else $error("erase started again at once");

   // ==========================================================
   // Byte channel
   property p_answer;
      rx.valid && rxReady |=> txValid || dead;
   endproperty
   a_answer: assert property (p_answer)
      else $error("accepted byte got no answer");
   // A lost reply byte would corrupt the checksum at the far end
   property p_hold;
      txValid && !txReady |=> txValid && $stable(txData);
   endproperty
   a_hold: assert property (p_hold)
      else $error("pending byte changed before it was taken");
   property p_sync;
      syncMode && rx.valid && rxReady && rx.rxErr |=> !(txValid && txData[3:0] == ACK_RXERR);
   endproperty
   a_sync: assert property (p_sync)
      else $error("receive error reported in clocked mode");
   property p_mode;
      syncMode |=> syncMode;
   endproperty
   a_mode: assert property (p_mode)
      else $error("latched mode changed");
   property p_dead;
      dead |=> dead && !rxReady && !txValid;
   endproperty
   a_dead: assert property (p_dead)
      else $error("aborted responder woke up");
   property p_ext;
      extStart |-> (extCmd == CMD_RAM || extCmd == CMD_SUM) ##1 !extStart;
   endproperty
   a_ext: assert property (p_ext)
      else $error("outside routine started with a wrong code");
endmodule

bind sbr_responder sbr_checker i_chk (.clock(clock), .rst_b(rst_b), .rx(rx), .rxReady(rxReady),
   .modeSync(modeSync), .baudOk(baudOk), .smallVariant(smallVariant), .headIndex(headIndex),
   .headByte(headByte), .txValid(txValid), .txData(txData), .txReady(txReady), .eraseStart(eraseStart),
   .eraseDone(eraseDone), .eraseErr(eraseErr), .extStart(extStart), .extCmd(extCmd), .extAck(extAck),
   .extDone(extDone), .syncMode(syncMode), .dead(dead));

`default_nettype wire

// >>> dv/sbr_host_model.sv
// Behavioural serial programming controller facing the responder
`default_nettype none

module sbr_host_model
   import sbr_pkg::*;
(
   input  wire logic       clock,
   output var sbr_rx_s     rx,
   input  wire logic       rxReady,
   input  wire logic       txValid,
   input  wire logic [7:0] txData,
   output var logic        txReady
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] got [$];
   logic       slow = 1'b0;

   initial begin
      rx = '{valid: 1'b0, data: 8'h00, rxErr: 1'b0};
   end

   // Slow mode stalls every other cycle so the responder must hold its byte
   always @(posedge clock) begin
      if (txValid && txReady)
         got.push_back(txData);
      #1;
      txReady = slow ? !txReady : 1'b1;
   end

   // Released data line shows the inverse so a stale byte cannot pass
   task automatic send(input logic [7:0] b, input logic e);
      int n;
      n = 0;
      @(posedge clock);
      #1;
      rx = '{valid: 1'b1, data: b, rxErr: e};
      do begin
         @(posedge clock);
         n++;
      end while (rxReady !== 1'b1 && n < 4000);
      #1;
      rx = '{valid: 1'b0, data: ~b, rxErr: 1'b0};
   endtask
endmodule

`default_nettype wire

// >>> dv/tb_serial_boot_command_responder.sv
// Self-checking bench for the serial boot command responder
`default_nettype none

module tb_serial_boot_command_responder
   import sbr_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clock, rst_b, modeSync, baudOk, smallVariant;
   logic        rxReady, txValid, txReady, eraseStart, extStart, syncMode, dead;
   logic        eraseDone = 1'b0, eraseErr = 1'b0, extDone = 1'b0;
   sbr_rx_s     rx;
   sbr_extack_s extAck = '0;
   logic [6:0]  headIndex;
   logic [7:0]  headByte, txData, extCmd;
   logic [7:0]  expInfo [5:93];
   logic [3:0]  ackIn [4] = '{4'b1100, 4'b1001, 4'b1010, 4'b1000};
   logic [7:0]  ackOut [4] = '{8'h21, 8'h28, 8'h11, 8'h10};
   int          fail_count = 0, n_compared = 0, cyc = 0, nStart = 0, nExt = 0;

   assign headByte = {1'b1, headIndex};

   sbr_responder i_dut (.clock(clock), .rst_b(rst_b), .rx(rx), .rxReady(rxReady), .modeSync(modeSync),
      .baudOk(baudOk), .smallVariant(smallVariant), .headIndex(headIndex), .headByte(headByte),
      .txValid(txValid), .txData(txData), .txReady(txReady), .eraseStart(eraseStart), .eraseDone(eraseDone),
      .eraseErr(eraseErr), .extStart(extStart), .extCmd(extCmd), .extAck(extAck), .extDone(extDone),
      .syncMode(syncMode), .dead(dead));
   sbr_host_model i_host (.clock(clock), .rx(rx), .rxReady(rxReady), .txValid(txValid), .txData(txData),
      .txReady(txReady));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Ceiling well above the several hundred cycles the tests need
   always @(posedge clock) begin
      cyc++;
      if (eraseStart === 1'b1)
         nStart++;
      if (extStart === 1'b1)
         nExt++;
      if (cyc == 60000) begin
         fail_count++;
         stop_test();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, want, seen);
      end
   endtask

   task automatic ack(input logic [7:0] want, input string nm);
      int n;
      n = 0;
      while (i_host.got.size() == 0 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      if (n > 0)
         #1;
      chk(nm, (i_host.got.size() > 0) ? i_host.got.pop_front() : 'x, want);
   endtask

   task automatic do_reset(input logic s, input logic b, input logic v);
      rst_b = 1'b0;
      modeSync = s;
      baudOk = b;
      smallVariant = v;
      repeat (12) @(posedge clock);
      #1;
      rst_b = 1'b1;
      i_host.got.delete();
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic erase_run(input logic err, input logic kerr);
      i_host.send(ERASE_KEY, kerr);
      ack(8'h54, "key echo");
      repeat (20) @(posedge clock);
      #1;
      eraseErr = err;
      eraseDone = 1'b1;
      ack(err ? 8'h4c : 8'h4f, "erase result");
      eraseDone = 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_info();
      logic [7:0] s;
      s = 8'h00;
      for (int i = 5; i <= 46; i++)
         expInfo[i] = (i <= 36) ? {1'b1, 7'(i)} : 8'h00;
      {expInfo[50], expInfo[49], expInfo[48], expInfo[47]} = 32'h3f80_0000;
      {expInfo[54], expInfo[53], expInfo[52], expInfo[51]} = smallVariant ? 32'h3f81_ffff : 32'h3f87_ffff;
      {expInfo[56], expInfo[55]} = smallVariant ? 16'h0004 : 16'h0006;
      for (int g = 0; g < 4; g++) begin
         {expInfo[60+9*g], expInfo[59+9*g], expInfo[58+9*g], expInfo[57+9*g]} = GROUP_START[g];
         {expInfo[64+9*g], expInfo[63+9*g], expInfo[62+9*g], expInfo[61+9*g]} = GROUP_HWORDS[g];
         expInfo[65+9*g] = smallVariant ? GROUP_CNT_SMALL[g] : GROUP_CNT_LARGE[g];
      end
      for (int i = 5; i <= 92; i++)
         s += expInfo[i];
      expInfo[93] = -s;
      i_host.slow = 1'b1;
      i_host.send(CMD_INFO, 1'b0);
      ack(8'h30, "info echo");
      for (int i = 5; i <= 93; i++)
         ack(expInfo[i], "info byte");
      i_host.slow = 1'b0;
      i_host.send(8'h77, 1'b0);
      ack(8'h31, "code after info");
      $display("test info reply done");
   endtask

   task automatic t_ext();
      i_host.send(CMD_ERASE, 1'b1);
      ack(8'h38, "command rx error");
      for (int k = 0; k < 4; k++) begin
         i_host.send(k == 3 ? CMD_RAM : CMD_SUM, 1'b0);
         ack(k == 3 ? CMD_RAM : CMD_SUM, "ext echo");
         chk("ext code", extCmd, k == 3 ? CMD_RAM : CMD_SUM);
         extAck = ackIn[k];
         @(posedge clock);
         #1;
         extAck = '0;
         ack(ackOut[k], "checksum ack");
      end
      chk("ext starts", nExt, 4);
      extDone = 1'b1;
      @(posedge clock);
      #1;
      extDone = 1'b0;
      i_host.send(8'he5, 1'b0);
      ack(8'h11, "undefined code");
      $display("test outside routines done");
   endtask

   task automatic t_erase();
      int s0;
      s0 = nStart;
      i_host.send(CMD_ERASE, 1'b0);
      ack(8'h40, "erase echo");
      i_host.send(8'h55, 1'b0);
      ack(8'h41, "wrong key");
      i_host.send(CMD_ERASE, 1'b0);
      ack(8'h40, "erase echo");
      i_host.send(ERASE_KEY, 1'b1);
      ack(8'h48, "key rx error");
      chk("erase starts", nStart, s0);
      for (int k = 0; k < 2; k++) begin
         i_host.send(CMD_ERASE, 1'b0);
         ack(8'h40, "erase echo");
         erase_run(k[0], 1'b0);
      end
      chk("erase starts", nStart, s0 + 2);
      i_host.send(8'h77, 1'b0);
      ack(8'h41, "code after erase");
      $display("test erase done");
   endtask

   task automatic t_mode(input logic s);
      do_reset(s, 1'b1, s);
      i_host.send(s ? MODE_SYNC : MODE_ASYNC, 1'b0);
      ack(s ? 8'h30 : 8'h86, "mode ack");
      chk("sync flag", syncMode, s);
      $display("test mode select done");
   endtask

   task automatic t_sync();
      i_host.send(CMD_ERASE, 1'b1);
      ack(8'h40, "sync erase echo");
      // Key with a receive error must still be taken in clocked mode
      erase_run(1'b0, 1'b1);
      i_host.send(CMD_SUM, 1'b0);
      ack(CMD_SUM, "sync ext echo");
      extAck = 4'h9;
      @(posedge clock);
      #1;
      extAck = '0;
      ack(8'h20, "sync checksum ack");
      extDone = 1'b1;
      @(posedge clock);
      #1;
      extDone = 1'b0;
      $display("test clocked mode done");
   endtask

   task automatic t_dead();
      do_reset(1'b0, 1'b0, 1'b0);
      i_host.send(MODE_ASYNC, 1'b0);
      repeat (20) @(posedge clock);
      #1;
      chk("reply count", i_host.got.size(), 0);
      chk("aborted", dead, 1'b1);
      chk("ready after abort", rxReady, 1'b0);
      $display("test bad baud done");
   endtask

   initial begin
      t_mode(1'b0);
      t_info();
      t_ext();
      t_erase();
      t_mode(1'b1);
      t_sync();
      t_info();
      t_dead();
      stop_test();
   end
endmodule

`default_nettype wire

// >>> verilog/sbr_ack_code.sv
// Forms an acknowledge byte from a command nibble and error flags
`default_nettype none

module sbr_ack_code
   import sbr_pkg::*;
(
   input  wire logic [3:0] upper,
   input  wire logic       rxErr,
   input  wire logic       bad,
   output logic      [7:0] code
);

   // ==========================================================
   // Receive error outranks a bad code; bits 1 and 2 stay zero
   always_comb begin
      if (rxErr) begin
         code = {upper, ACK_RXERR};
      end else if (bad) begin
         code = {upper, ACK_BAD};
      end else begin
         code = {upper, ACK_GOOD};
      end
   end

endmodule

`default_nettype wire

// >>> verilog/sbr_checksum.sv
// Running byte sum whose two's complement forms a reply checksum
`default_nettype none

module sbr_checksum
   import sbr_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       clear,
   input  wire logic       add,
   input  wire logic [7:0] data,
   output logic      [7:0] check
);

   logic [7:0] sum;

   // ==========================================================
   // Accumulator, carries dropped by the 8-bit width
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sum <= 8'h00;
      end else if (clear) begin
         sum <= 8'h00;
      end else if (add) begin
         sum <= sum + data;
      end
   end

   assign check = 8'h00 - sum;

endmodule

`default_nettype wire

// >>> verilog/sbr_pkg.sv
// Constants, codes and carrier types of the serial boot command responder
`default_nettype none

package sbr_pkg;

   // ==========================================================
   // Byte codes on the serial channel
   localparam logic [7:0] MODE_ASYNC = 8'h86;
   localparam logic [7:0] MODE_SYNC  = 8'h30;
   localparam logic [7:0] CMD_RAM    = 8'h10;
   localparam logic [7:0] CMD_SUM    = 8'h20;
   localparam logic [7:0] CMD_INFO   = 8'h30;
   localparam logic [7:0] CMD_ERASE  = 8'h40;
   localparam logic [7:0] ERASE_KEY  = 8'h54;
   localparam logic [7:0] ERASE_OK   = 8'h4f;
   localparam logic [7:0] ERASE_FAIL = 8'h4c;

   // ==========================================================
   // Acknowledge low nibbles, then upper nibbles for password errors and after reset
   localparam logic [3:0] ACK_RXERR  = 4'h8;
   localparam logic [3:0] ACK_BAD    = 4'h1;
   localparam logic [3:0] ACK_GOOD   = 4'h0;
   localparam logic [3:0] PWD_NIBBLE = 4'h1;
   localparam logic [3:0] RESET_NIBBLE = 4'h0;

   // ==========================================================
   // Product-information reply byte positions
   localparam logic [6:0] IDX_FIRST       = 7'd5;
   localparam logic [6:0] IDX_HEAD_LAST   = 7'd36;
   localparam logic [6:0] IDX_ZERO_LAST   = 7'd46;
   localparam logic [6:0] IDX_START_LAST  = 7'd50;
   localparam logic [6:0] IDX_END_LAST    = 7'd54;
   localparam logic [6:0] IDX_COUNT_LAST  = 7'd56;
   localparam logic [6:0] IDX_GROUP_FIRST = 7'd57;
   localparam logic [6:0] IDX_GROUP_LAST  = 7'd92;
   localparam logic [6:0] IDX_CHECKSUM    = 7'd93;
   localparam logic [3:0] GROUP_OFF_LAST  = 4'd8;
   localparam logic [3:0] GROUP_OFF_SIZE  = 4'd4;
   localparam logic [3:0] GROUP_OFF_COUNT = 4'd8;

   // ==========================================================
   // Flash geometry
   localparam logic [31:0] FLASH_START     = 32'h3f80_0000;
   localparam logic [31:0] FLASH_END_LARGE = 32'h3f87_ffff;
   localparam logic [31:0] FLASH_END_SMALL = 32'h3f81_ffff;
   localparam logic [15:0] BLOCKS_LARGE    = 16'h0006;
   localparam logic [15:0] BLOCKS_SMALL    = 16'h0004;
   localparam logic [31:0] GROUP_START [4] = '{32'h3f80_0000, 32'h3f80_4000, 32'h3f81_4000, 32'h3f82_4000};
   localparam logic [31:0] GROUP_HWORDS [4] = '{32'h0000_2000, 32'h0000_4000, 32'h0000_8000, 32'h0001_0000};
   localparam logic [7:0]  GROUP_CNT_LARGE [4] = '{8'h01, 8'h02, 8'h01, 8'h02};
   localparam logic [7:0]  GROUP_CNT_SMALL [4] = '{8'h01, 8'h02, 8'h01, 8'h00};

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       rxErr;
   } sbr_rx_s;

   typedef struct packed {
      logic       valid;
      logic       chkErr;
      logic       pwdErr;
      logic       rxErr;
   } sbr_extack_s;

   typedef enum logic [2:0] {
      ST_MODE  = 3'b000,
      ST_CMD   = 3'b001,
      ST_INFO  = 3'b011,
      ST_KEY   = 3'b010,
      ST_ERASE = 3'b110,
      ST_EXT   = 3'b111,
      ST_DEAD  = 3'b101
   } sbr_state_e;

endpackage

`default_nettype wire

// >>> verilog/sbr_responder.sv
// Serial boot command responder: mode byte, command echo, info reply tail, chip erase
`default_nettype none

module sbr_responder
   import sbr_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire sbr_rx_s     rx,
   output logic             rxReady,
   input  wire logic        modeSync,
   input  wire logic        baudOk,
   input  wire logic        smallVariant,
   output logic       [6:0] headIndex,
   input  wire logic  [7:0] headByte,
   output logic             txValid,
   output logic       [7:0] txData,
   input  wire logic        txReady,
   output logic             eraseStart,
   input  wire logic        eraseDone,
   input  wire logic        eraseErr,
   output logic             extStart,
   output logic       [7:0] extCmd,
   input  wire sbr_extack_s extAck,
   input  wire logic        extDone,
   output logic             syncMode,
   output logic             dead
);

   // ==========================================================
   // Declarations
   sbr_state_e state;
   sbr_state_e next_state;
   logic [6:0] idx;
   logic [1:0] grp;
   logic [3:0] off;
   logic [3:0] prevNibble;
   logic [3:0] cmdNibble;
   logic       txFree;
   logic       rxTake;
   logic       rxErrEff;
   logic       sendNow;
   logic [7:0] sendByte;
   logic       sumClear;
   logic       sumAdd;
   logic       idxStep;
   logic       latchCmd;
   logic       latchSync;
   logic       startErase;
   logic       startExt;
   logic [7:0] sumCheck;
   logic [3:0] ackUpper;
   logic       ackRx;
   logic       ackBad;
   logic [7:0] ackByte;
   logic [7:0] infoByte;
   logic [31:0] endAddr;
   logic [15:0] blockCount;
   logic [7:0] grpCount;
   logic [1:0] lane;

   // ==========================================================
   // Handshake
   // A byte is only taken when the transmit slot is free, so the answer to a taken byte is never dropped
   assign txFree  = !txValid || txReady;
   assign rxReady = txFree && (state == ST_MODE || state == ST_CMD || state == ST_KEY);
   assign rxTake  = rx.valid && rxReady;
   assign rxErrEff = rx.rxErr && !syncMode;
   assign headIndex = idx;
   assign dead = (state == ST_DEAD);

   // ==========================================================
   // Information reply byte
   assign endAddr    = smallVariant ? FLASH_END_SMALL : FLASH_END_LARGE;
   assign blockCount = smallVariant ? BLOCKS_SMALL : BLOCKS_LARGE;
   assign grpCount   = smallVariant ? GROUP_CNT_SMALL[grp] : GROUP_CNT_LARGE[grp];
   // Field starts sit one below a multiple of four, so idx+1 selects the lane
   assign lane = 2'(idx + 7'd1);

   always_comb begin
      infoByte = 8'h00;
      if (idx <= IDX_HEAD_LAST) begin
         infoByte = headByte;
      end else if (idx <= IDX_ZERO_LAST) begin
         infoByte = 8'h00;
      end else if (idx <= IDX_START_LAST) begin
         infoByte = FLASH_START[8*lane +: 8];
      end else if (idx <= IDX_END_LAST) begin
         infoByte = endAddr[8*lane +: 8];
      end else if (idx <= IDX_COUNT_LAST) begin
         infoByte = blockCount[8*lane[0] +: 8];
      end else if (idx <= IDX_GROUP_LAST) begin
         if (off < GROUP_OFF_SIZE) begin
            infoByte = GROUP_START[grp][8*off[1:0] +: 8];
         end else if (off < GROUP_OFF_COUNT) begin
            infoByte = GROUP_HWORDS[grp][8*off[1:0] +: 8];
         end else begin
            infoByte = grpCount;
         end
      end else begin
         infoByte = sumCheck;
      end
   end

   sbr_checksum u_sum (
      .clock (clock),
      .rst_b (rst_b),
      .clear (sumClear),
      .add   (sumAdd),
      .data  (infoByte),
      .check (sumCheck)
   );

   sbr_ack_code u_ack (
      .upper (ackUpper),
      .rxErr (ackRx),
      .bad   (ackBad),
      .code  (ackByte)
   );

   // ==========================================================
   // Sequencer
   always_comb begin
      next_state = state;
      sendNow    = 1'b0;
      sendByte   = 8'h00;
      sumClear   = 1'b0;
      sumAdd     = 1'b0;
      idxStep    = 1'b0;
      latchCmd   = 1'b0;
      latchSync  = 1'b0;
      startErase = 1'b0;
      startExt   = 1'b0;
      ackUpper   = prevNibble;
      ackRx      = 1'b0;
      ackBad     = 1'b0;
      unique case (state)
         ST_MODE: begin
            if (rxTake) begin
               latchSync = 1'b1;
               if (!modeSync && !baudOk) begin
                  next_state = ST_DEAD;
               end else begin
                  sendNow    = 1'b1;
                  sendByte   = modeSync ? MODE_SYNC : MODE_ASYNC;
                  next_state = ST_CMD;
               end
            end
         end
         ST_CMD: begin
            if (rxTake) begin
               sendNow = 1'b1;
               if (rxErrEff) begin
                  ackRx    = 1'b1;
                  sendByte = ackByte;
               end else begin
                  latchCmd = 1'b1;
                  sendByte = rx.data;
                  unique case (rx.data)
                     CMD_INFO: begin
                        sumClear   = 1'b1;
                        next_state = ST_INFO;
                     end
                     CMD_ERASE: begin
                        next_state = ST_KEY;
                     end
                     CMD_RAM, CMD_SUM: begin
                        startExt   = 1'b1;
                        next_state = ST_EXT;
                     end
                     default: begin
                        latchCmd = 1'b0;
                        ackBad   = 1'b1;
                        sendByte = ackByte;
                     end
                  endcase
               end
            end
         end
         ST_INFO: begin
            if (txFree) begin
               sendNow  = 1'b1;
               sendByte = infoByte;
               idxStep  = 1'b1;
               sumAdd   = (idx != IDX_CHECKSUM);
               if (idx == IDX_CHECKSUM) begin
                  next_state = ST_CMD;
               end
            end
         end
         ST_KEY: begin
            if (rxTake) begin
               sendNow    = 1'b1;
               ackUpper   = cmdNibble;
               next_state = ST_CMD;
               if (rxErrEff) begin
                  ackRx    = 1'b1;
                  sendByte = ackByte;
               end else if (rx.data == ERASE_KEY) begin
                  sendByte   = ERASE_KEY;
                  startErase = 1'b1;
                  next_state = ST_ERASE;
               end else begin
                  ackBad   = 1'b1;
                  sendByte = ackByte;
               end
            end
         end
         ST_ERASE: begin
            if (eraseDone && txFree) begin
               sendNow    = 1'b1;
               sendByte   = eraseErr ? ERASE_FAIL : ERASE_OK;
               next_state = ST_CMD;
            end
         end
         ST_EXT: begin
            ackUpper = extAck.pwdErr ? PWD_NIBBLE : cmdNibble;
            ackRx    = extAck.rxErr && !syncMode;
            ackBad   = extAck.chkErr || extAck.pwdErr;
            if (extAck.valid && txFree) begin
               sendNow  = 1'b1;
               sendByte = ackByte;
               if (ackRx || ackBad) begin
                  next_state = ST_CMD;
               end
            end
            if (extDone) begin
               next_state = ST_CMD;
            end
         end
         ST_DEAD: begin
            next_state = ST_DEAD;
         end
         default: begin
            next_state = ST_MODE;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_MODE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Reply position counters
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         idx <= IDX_FIRST;
         grp <= 2'b00;
         off <= 4'h0;
      end else if (sumClear) begin
         idx <= IDX_FIRST;
         grp <= 2'b00;
         off <= 4'h0;
      end else if (idxStep) begin
         idx <= idx + 7'd1;
         if (idx >= IDX_GROUP_FIRST) begin
            if (off == GROUP_OFF_LAST) begin
               off <= 4'h0;
               grp <= grp + 2'b01;
            end else begin
               off <= off + 4'h1;
            end
         end
      end
   end

   // ==========================================================
   // Command memory; the previous nibble feeds error answers
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         prevNibble <= RESET_NIBBLE;
         cmdNibble  <= RESET_NIBBLE;
         extCmd     <= 8'h00;
      end else if (latchCmd) begin
         prevNibble <= rx.data[7:4];
         cmdNibble  <= rx.data[7:4];
         extCmd     <= rx.data;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         syncMode <= 1'b0;
      end else if (latchSync) begin
         syncMode <= modeSync;
      end
   end

   // ==========================================================
   // Transmit slot
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         txValid <= 1'b0;
         txData  <= 8'h00;
      end else if (sendNow) begin
         txValid <= 1'b1;
         txData  <= sendByte;
      end else if (txReady) begin
         txValid <= 1'b0;
      end
   end

   // ==========================================================
   // Start pulses to the erase engine and the outside routines
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         eraseStart <= 1'b0;
         extStart   <= 1'b0;
      end else begin
         eraseStart <= startErase;
         extStart   <= startExt;
      end
   end

endmodule

`default_nettype wire
